// ---- inc/smp_pkg.sv ----
package smp_pkg;

    // Register map.
    localparam int          ADDR_W        = 16;
    localparam logic [15:0] RXFILT_ADDR   = 16'h00B0;
    localparam logic [15:0] MPMODE_ADDR   = 16'h00BB;
    localparam logic [15:0] I2CCOND_ADDR  = 16'h00BC;
    localparam logic [7:0]  RXFILT_RST    = 8'h00;
    localparam logic [7:0]  MPMODE_RST    = 8'h00;
    localparam logic [7:0]  I2CCOND_RST   = 8'h00;
    localparam logic [7:0]  RD_NONE       = 8'h00;

    // Field positions.
    localparam int FILT_EN_BIT  = 2;
    localparam int MP_EN_BIT    = 0;
    localparam int ID_WAIT_BIT  = 4;
    localparam int MP_RSV_BIT   = 7;
    localparam int START_BIT    = 0;
    localparam int RESTART_BIT  = 1;
    localparam int STOP_BIT     = 2;
    localparam int COND_SEL_BIT = 3;
    localparam int ACK_VAL_BIT  = 4;
    localparam int ACK_SEL_BIT  = 5;
    localparam int SCL_HALT_BIT = 6;
    localparam int SCL_HOLD_BIT = 7;

    // Serial mode field codes.
    localparam logic [2:0] MODE_SYNC = 3'h1;
    localparam logic [2:0] MODE_I2C  = 3'h2;

    // Timing of one step of a bus condition waveform, and the receive filter length in samples.
    localparam int CLK_PERIOD_NS = 40;
    localparam int COND_STEP_NS  = 5000;
    localparam int COND_STEP_CYC = (COND_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_LEN      = 3;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       bit9;
        logic       framing_err;
        logic       overrun;
    } rx_frame_s;

endpackage

// ---- logic/serial_multiproc_i2c_ctrl.sv ----
`timescale 1ns/1ps
module serial_multiproc_i2c_ctrl #(
    parameter int COND_STEP_CYC = smp_pkg::COND_STEP_CYC
) (
    // Clock and reset.
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst,
    // Register port.
    input  wire logic [smp_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [7:0]                i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic      [7:0]                o_rdata,
    // Settings from the serial mode register.
    input  wire logic [2:0]                i_serial_mode_field,
    input  wire logic                      i_parity_enable,
    input  wire logic                      i_parity_odd_even,
    // Receiver datapath.
    input  wire smp_pkg::rx_frame_s        i_rx_frame,
    output smp_pkg::rx_frame_s             o_rx_frame,
    output logic                           o_parity_active,
    output logic                           o_parity_odd,
    // Serial datapath pin sources.
    input  wire logic                      i_ser_scl,
    input  wire logic                      i_ser_sda,
    input  wire logic                      i_scl_stop_req,
    // Pins.
    input  wire logic                      i_serial_rx_pin,
    input  wire logic                      i_scl_in,
    input  wire logic                      i_sda_in,
    output logic                           o_rx_line,
    output logic                           o_scl_level,
    output logic                           o_sda_level,
    output logic                           o_scl_out,
    output logic                           o_scl_oe,
    output logic                           o_sda_out,
    output logic                           o_sda_oe,
    output logic                           o_cond_busy
);

    localparam int STEP_W     = $clog2(COND_STEP_CYC + 1);
    localparam int SEQ_MAX    = 4 * COND_STEP_CYC + 4;
    localparam int FILT_LEN_W = smp_pkg::FILT_LEN - 1;

    if (COND_STEP_CYC < 1 || COND_STEP_CYC > 249) begin : g_bad_step
        $error("COND_STEP_CYC must lie between 1 and 249");
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_PRE_HI = 8'h02,
        ST_SCL_HI = 8'h04,
        ST_SDA_LO = 8'h08,
        ST_SCL_LO = 8'h10,
        ST_P_LO   = 8'h20,
        ST_P_SCL  = 8'h40,
        ST_P_SDA  = 8'h80
    } cond_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and receive filter.

    logic [2:0]          pin_raw;
    logic [2:0]          sync1_r;
    logic [2:0]          sync2_r;
    logic [FILT_LEN_W:0] filt_r;
    logic                filt_on;
    logic                rx_filt_en_r;

    assign pin_raw = {i_sda_in, i_scl_in, i_serial_rx_pin};

    generate
        for (genvar g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    sync1_r[g] <= 1'b1;
                    sync2_r[g] <= 1'b1;
                end else begin
                    sync1_r[g] <= pin_raw[g];
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    // The filter is bypassed in synchronous and I2C modes even if left enabled.
    assign filt_on = rx_filt_en_r && (i_serial_mode_field != smp_pkg::MODE_SYNC)
                     && (i_serial_mode_field != smp_pkg::MODE_I2C);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            filt_r      <= '1;
            o_rx_line   <= 1'b1;
            o_scl_level <= 1'b1;
            o_sda_level <= 1'b1;
        end else begin
            filt_r      <= {filt_r[FILT_LEN_W-1:0], sync2_r[0]};
            o_scl_level <= sync2_r[1];
            o_sda_level <= sync2_r[2];
            if (!filt_on) begin
                o_rx_line <= sync2_r[0];
            end else if (&filt_r) begin
                o_rx_line <= 1'b1;
            end else if (~|filt_r) begin
                o_rx_line <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic        wr_filt;
    logic        wr_mp;
    logic        wr_cond;
    logic        mp_en_r;
    logic        id_wait_r;
    logic        mp_rsv_r;
    logic [2:0]  req_r;
    logic [2:0]  req_nxt;
    logic        cond_sel_r;
    logic        ack_val_r;
    logic        ack_sel_r;
    logic        scl_halt_r;
    logic        scl_hold_r;
    logic        idw_hit;
    logic        idw_drop;
    logic        seq_done;
    logic [1:0]  cur_r;

    assign wr_filt = i_wr && (i_addr == smp_pkg::RXFILT_ADDR);
    assign wr_mp   = i_wr && (i_addr == smp_pkg::MPMODE_ADDR);
    assign wr_cond = i_wr && (i_addr == smp_pkg::I2CCOND_ADDR);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_filt_en_r <= smp_pkg::RXFILT_RST[smp_pkg::FILT_EN_BIT];
        end else if (wr_filt) begin
            rx_filt_en_r <= i_wdata[smp_pkg::FILT_EN_BIT];
        end
    end

    // A software write to ID-wait takes priority over the hardware clear.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mp_en_r   <= smp_pkg::MPMODE_RST[smp_pkg::MP_EN_BIT];
            id_wait_r <= smp_pkg::MPMODE_RST[smp_pkg::ID_WAIT_BIT];
            mp_rsv_r  <= smp_pkg::MPMODE_RST[smp_pkg::MP_RSV_BIT];
        end else if (wr_mp) begin
            mp_en_r   <= i_wdata[smp_pkg::MP_EN_BIT];
            id_wait_r <= i_wdata[smp_pkg::ID_WAIT_BIT];
            mp_rsv_r  <= i_wdata[smp_pkg::MP_RSV_BIT];
        end else if (idw_hit) begin
            id_wait_r <= 1'b0;
        end
    end

    always_comb begin
        req_nxt = req_r;
        if (seq_done) begin
            req_nxt[cur_r] = 1'b0;
        end
        if (wr_cond) begin
            req_nxt = i_wdata[smp_pkg::STOP_BIT:smp_pkg::START_BIT];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            req_r      <= smp_pkg::I2CCOND_RST[smp_pkg::STOP_BIT:smp_pkg::START_BIT];
            cond_sel_r <= smp_pkg::I2CCOND_RST[smp_pkg::COND_SEL_BIT];
            ack_val_r  <= smp_pkg::I2CCOND_RST[smp_pkg::ACK_VAL_BIT];
            ack_sel_r  <= smp_pkg::I2CCOND_RST[smp_pkg::ACK_SEL_BIT];
            scl_halt_r <= smp_pkg::I2CCOND_RST[smp_pkg::SCL_HALT_BIT];
            scl_hold_r <= smp_pkg::I2CCOND_RST[smp_pkg::SCL_HOLD_BIT];
        end else begin
            req_r <= req_nxt;
            if (wr_cond) begin
                cond_sel_r <= i_wdata[smp_pkg::COND_SEL_BIT];
                ack_val_r  <= i_wdata[smp_pkg::ACK_VAL_BIT];
                ack_sel_r  <= i_wdata[smp_pkg::ACK_SEL_BIT];
                scl_halt_r <= i_wdata[smp_pkg::SCL_HALT_BIT];
                scl_hold_r <= i_wdata[smp_pkg::SCL_HOLD_BIT];
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= smp_pkg::RD_NONE;
        end else if (!i_rd) begin
            o_rdata <= smp_pkg::RD_NONE;
        end else if (i_addr == smp_pkg::RXFILT_ADDR) begin
            o_rdata <= {5'h00, rx_filt_en_r, 2'h0};
        end else if (i_addr == smp_pkg::MPMODE_ADDR) begin
            o_rdata <= {mp_rsv_r, 2'h0, id_wait_r, 3'h0, mp_en_r};
        end else if (i_addr == smp_pkg::I2CCOND_ADDR) begin
            o_rdata <= {scl_hold_r, scl_halt_r, ack_sel_r, ack_val_r, cond_sel_r, req_r};
        end else begin
            o_rdata <= smp_pkg::RD_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Multiprocessor reception.

    assign idw_drop = i_rx_frame.valid && mp_en_r && id_wait_r && !i_rx_frame.bit9;
    assign idw_hit  = i_rx_frame.valid && mp_en_r && id_wait_r && i_rx_frame.bit9;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_frame      <= '0;
            o_parity_active <= 1'b0;
            o_parity_odd    <= 1'b0;
        end else begin
            o_parity_active <= i_parity_enable && !mp_en_r;
            o_parity_odd    <= i_parity_odd_even && !mp_en_r;
            o_rx_frame      <= i_rx_frame;
            if (idw_drop) begin
                o_rx_frame <= '0;
            end
        end
    end

    discard_id_wait_a: assert property (
        idw_drop |=> !o_rx_frame.valid
    ) else $error("frame with multiprocessor bit 0 passed during ID-wait");
    discard_no_flags_a: assert property (
        idw_drop |=> !o_rx_frame.overrun && !o_rx_frame.framing_err
    ) else $error("error flag raised by a discarded frame");
    id_wait_clear_a: assert property (
        idw_hit && !wr_mp |=> !id_wait_r && o_rx_frame.valid
    ) else $error("ID frame did not clear ID-wait or was lost");
    id_wait_inert_a: assert property (
        i_rx_frame.valid && !mp_en_r |=> o_rx_frame.valid
    ) else $error("ID-wait dropped a frame with multiprocessor mode off");
    mp_flag_report_a: assert property (
        i_rx_frame.valid && !idw_drop |=> o_rx_frame.bit9 == $past(i_rx_frame.bit9)
    ) else $error("received multiprocessor bit not reported");
    parity_override_a: assert property (
        mp_en_r && $past(mp_en_r) |-> !o_parity_active && !o_parity_odd
    ) else $error("parity active while multiprocessor mode is on");
    mp_enable_write_a: assert property (
        wr_mp |=> mp_en_r == $past(i_wdata[smp_pkg::MP_EN_BIT])
    ) else $error("multiprocessor enable did not follow the write");

    ////////////////////////////////////////////////////////////////////////////
    // Condition generator.

    cond_state_e       state_r;
    logic [STEP_W-1:0] step_r;
    logic              fsm_scl;
    logic              fsm_sda;
    logic              step_end;

    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(COND_STEP_CYC - 1);

    assign step_end = (step_r == STEP_LAST);
    assign seq_done = step_end && (state_r inside {ST_SCL_LO, ST_P_SDA});

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            step_r  <= '0;
            cur_r   <= 2'h0;
        end else begin
            step_r <= (state_r == ST_IDLE || step_end) ? '0 : step_r + 1'b1;
            case (state_r)
                ST_IDLE: begin
                    if (req_r[smp_pkg::START_BIT]) begin
                        cur_r   <= 2'(smp_pkg::START_BIT);
                        state_r <= ST_SCL_HI;
                    end else if (req_r[smp_pkg::RESTART_BIT]) begin
                        cur_r   <= 2'(smp_pkg::RESTART_BIT);
                        state_r <= ST_PRE_HI;
                    end else if (req_r[smp_pkg::STOP_BIT]) begin
                        cur_r   <= 2'(smp_pkg::STOP_BIT);
                        state_r <= ST_P_LO;
                    end
                end
                ST_PRE_HI: if (step_end) state_r <= ST_SCL_HI;
                ST_SCL_HI: if (step_end) state_r <= ST_SDA_LO;
                ST_SDA_LO: if (step_end) state_r <= ST_SCL_LO;
                ST_SCL_LO: if (step_end) state_r <= ST_IDLE;
                ST_P_LO:   if (step_end) state_r <= ST_P_SCL;
                ST_P_SCL:  if (step_end) state_r <= ST_P_SDA;
                ST_P_SDA:  if (step_end) state_r <= ST_IDLE;
                default:   state_r <= ST_IDLE;
            endcase
        end
    end

    always_comb begin
        fsm_scl = !(state_r inside {ST_PRE_HI, ST_SCL_LO, ST_P_LO});
        fsm_sda = !(state_r inside {ST_SDA_LO, ST_SCL_LO, ST_P_LO, ST_P_SCL});
    end

    // Open-drain drive: the output level is always low, the enable pulls.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_scl_out   <= 1'b0;
            o_sda_out   <= 1'b0;
            o_scl_oe    <= 1'b0;
            o_sda_oe    <= 1'b0;
            o_cond_busy <= 1'b0;
        end else begin
            o_cond_busy <= (state_r != ST_IDLE);
            if (scl_hold_r) begin
                o_scl_oe <= 1'b1;
            end else if (cond_sel_r && state_r != ST_IDLE) begin
                o_scl_oe <= !fsm_scl;
            end else if (scl_halt_r && i_scl_stop_req) begin
                o_scl_oe <= 1'b0;
            end else begin
                o_scl_oe <= !i_ser_scl;
            end
            if (cond_sel_r && state_r != ST_IDLE) begin
                o_sda_oe <= !fsm_sda;
            end else if (ack_sel_r) begin
                o_sda_oe <= !ack_val_r;
            end else begin
                o_sda_oe <= !i_ser_sda;
            end
        end
    end

    req_clear_a: assert property (
        state_r != ST_IDLE |-> ##[0:SEQ_MAX] state_r == ST_IDLE
    ) else $error("condition sequence did not complete in time");
    scl_hold_a: assert property (
        scl_hold_r |=> o_scl_oe
    ) else $error("SCL not held low");
    cond_drive_a: assert property (
        !scl_hold_r && cond_sel_r && state_r != ST_IDLE |=> o_scl_oe == !$past(fsm_scl)
    ) else $error("condition waveform not on SCL");
    ack_drive_a: assert property (
        ack_sel_r && !(cond_sel_r && state_r != ST_IDLE) |=> o_sda_oe == !$past(ack_val_r)
    ) else $error("ack value not on SDA");
    scl_halt_a: assert property (
        scl_halt_r && i_scl_stop_req && !scl_hold_r && !cond_sel_r |=> !o_scl_oe
    ) else $error("SCL not stopped");

endmodule

// ---- test/serial_node.sv ----
`timescale 1ns/1ps
module serial_node (
    // Clock.
    input  wire logic          i_core_clk,
    // Frame request from the bench.
    input  wire logic          i_send,
    input  wire logic [7:0]    i_data,
    input  wire logic          i_bit9,
    input  wire logic          i_fe,
    input  wire logic          i_ov,
    // Open-drain enables of the device.
    input  wire logic          i_scl_oe,
    input  wire logic          i_sda_oe,
    // Frame to the receiver and bus levels.
    output smp_pkg::rx_frame_s o_frame,
    output logic               o_scl,
    output logic               o_sda
);
    // Both bus lines have a pull-up, so a released line reads high.
    assign o_scl = ~i_scl_oe;
    assign o_sda = ~i_sda_oe;
    initial o_frame = '0;
    // Outside a frame the fields toggle so stale values never pass for data.
    always @(posedge i_core_clk) begin
        if (i_send) begin
            o_frame <= '{valid: 1'h1, data: i_data, bit9: i_bit9,
                         framing_err: i_fe, overrun: i_ov};
        end else begin
            o_frame <= '{valid: 1'h0, data: ~o_frame.data, bit9: ~o_frame.bit9,
                         framing_err: ~o_frame.framing_err, overrun: ~o_frame.overrun};
        end
    end
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    localparam int          STEP = 3;
    localparam logic [15:0] RA   = smp_pkg::RXFILT_ADDR;
    localparam logic [15:0] MA   = smp_pkg::MPMODE_ADDR;
    localparam logic [15:0] CA   = smp_pkg::I2CCOND_ADDR;
    localparam logic [15:0] NA   = 16'h00BD;
    // Each entry: register value, scl source, sda source, stop request, scl oe, sda oe.
    localparam logic [12:0] PIN_TAB [7] = '{13'h0419, 13'h0610, 13'h0011, 13'h101A,
                                            13'h080C, 13'h000E, 13'h180E};
    logic               clk, rst, wr, rd, par_en, par_odd, ser_scl, ser_sda, stop_req, rx_pin;
    logic               rx_line, scl_lvl, sda_lvl, scl_out, sda_out, scl_oe, sda_oe, busy;
    logic               busy_seen, send, f_b9, f_fe, f_ov, scl_w, sda_w, prev_scl, prev_sda;
    logic               par_act, par_odd_q, mpm, idw, b9, lo;
    logic [15:0]        addr;
    logic [7:0]         wdata, rdata, f_data, r;
    logic [2:0]         mode;
    smp_pkg::rx_frame_s frm_in, frm_out, fr;
    int                 n_start, n_stop, n_mismatch, total_checks, i, j;

    serial_multiproc_i2c_ctrl #(.COND_STEP_CYC(STEP)) uut (
        .i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_serial_mode_field(mode), .i_parity_enable(par_en),
        .i_parity_odd_even(par_odd), .i_rx_frame(frm_in), .o_rx_frame(frm_out),
        .o_parity_active(par_act), .o_parity_odd(par_odd_q), .i_ser_scl(ser_scl),
        .i_ser_sda(ser_sda), .i_scl_stop_req(stop_req), .i_serial_rx_pin(rx_pin),
        .i_scl_in(scl_w), .i_sda_in(sda_w), .o_rx_line(rx_line), .o_scl_level(scl_lvl),
        .o_sda_level(sda_lvl), .o_scl_out(scl_out), .o_scl_oe(scl_oe), .o_sda_out(sda_out),
        .o_sda_oe(sda_oe), .o_cond_busy(busy));
    serial_node node (
        .i_core_clk(clk), .i_send(send), .i_data(f_data), .i_bit9(f_b9), .i_fe(f_fe),
        .i_ov(f_ov), .i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .o_frame(frm_in), .o_scl(scl_w),
        .o_sda(sda_w));

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    // Counts start and stop conditions seen on the bus wires.
    always @(posedge clk) begin
        if (!rst && prev_scl && scl_w && prev_sda != sda_w) begin
            if (sda_w)
                n_stop++;
            else
                n_start++;
        end
        prev_scl <= scl_w;
        prev_sda <= sda_w;
        busy_seen <= busy_seen | busy;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdata;
    endtask

    task automatic chk_reg(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd_reg(a, v);
        chk(16'(v), 16'(exp));
    endtask

    task automatic send_frame(input logic [7:0] d, input logic b, input logic fe,
                              input logic ov, output smp_pkg::rx_frame_s got);
        @(posedge clk);
        send <= 1'h1;
        {f_data, f_b9, f_fe, f_ov} <= {d, b, fe, ov};
        @(posedge clk);
        send <= 1'h0;
        @(posedge clk);
        #1 got = frm_out;
    endtask

    function automatic smp_pkg::rx_frame_s exp_frame(input logic drop, input logic [7:0] d,
                                                     input logic b, input logic fe,
                                                     input logic ov);
        exp_frame = drop ? '0 : '{1'h1, d, b, fe, ov};
    endfunction

    task automatic cond_run(input logic [7:0] req, input logic cancel, input int ds,
                            input int dp);
        int s0;
        int p0;
        int k;
        logic [7:0] v;
        s0 = n_start;
        p0 = n_stop;
        wr_reg(CA, req);
        if (cancel)
            wr_reg(CA, req & 8'hFB);
        v = req;
        k = 0;
        while ((v[2:0] != 3'h0 || busy) && k < 60) begin
            rd_reg(CA, v);
            k++;
        end
        if (k == 60) begin
            n_mismatch++;
            $display("unexpected hang at %0t: request never completed", $time);
            close_out();
        end
        chk(16'(v), 16'(req & 8'hF8));
        settle(4);
        chk(16'(n_start - s0), 16'(ds));
        chk(16'(n_stop - p0), 16'(dp));
    endtask

    initial begin
        {rst, wr, rd, par_en, par_odd, stop_req, send, f_b9, f_fe, f_ov} = 10'h200;
        {ser_scl, ser_sda, rx_pin, prev_scl, prev_sda} = 5'h1F;
        {addr, wdata, f_data, mode, busy_seen} = '0;
        {n_start, n_stop, n_mismatch, total_checks} = '0;
        r = 8'($urandom(30));
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        chk_reg(RA, smp_pkg::RXFILT_RST);
        chk_reg(MA, smp_pkg::MPMODE_RST);
        chk_reg(CA, smp_pkg::I2CCOND_RST);
        for (i = 0; i < 8; i++) begin
            r = (i == 0) ? 8'hFF : 8'($urandom);
            wr_reg(RA, r);
            wr_reg(MA, r);
            wr_reg(CA, r & 8'hF8);
            wr_reg(NA, ~r);
            chk_reg(RA, r & 8'h04);
            chk_reg(MA, r & 8'h91);
            chk_reg(CA, r & 8'hF8);
            chk_reg(NA, smp_pkg::RD_NONE);
        end
        mode <= 3'h0; // asynchronous mode
        wr_reg(RA, 8'h04);
        for (j = 0; j < 2; j++) begin
            settle(6);
            lo = 1'h1;
            @(posedge clk);
            rx_pin <= 1'h0;
            @(posedge clk);
            rx_pin <= 1'h1;
            repeat (8) begin
                @(posedge clk);
                #1 lo = lo & rx_line;
            end
            chk(16'(lo), 16'(j == 0));
            wr_reg(RA, 8'h00);
        end
        // Multiprocessor on with ID-wait, then off with ID-wait left set.
        for (j = 0; j < 2; j++) begin
            mpm = (j == 0);
            idw = 1'h1;
            wr_reg(MA, {3'h0, 1'h1, 3'h0, mpm});
            for (i = 0; i < 8; i++) begin
                b9 = (i == 4) ? 1'h1 : (i < 4) ? 1'h0 : 1'($urandom);
                r = 8'($urandom);
                send_frame(r, b9, 1'(i), 1'(i >> 1), fr);
                chk(16'(fr), 16'(exp_frame(mpm & idw & ~b9, r, b9, 1'(i), 1'(i >> 1))));
                if (mpm & b9)
                    idw = 1'h0;
                chk_reg(MA, {3'h0, idw, 3'h0, mpm});
            end
        end
        for (i = 0; i < 8; i++) begin
            wr_reg(MA, {7'h00, 1'(i >> 2)});
            @(posedge clk);
            {par_odd, par_en} <= 2'(i);
            settle(3);
            chk(16'({par_act, par_odd_q}), 16'({i[0], i[1]} & {2{~i[2]}}));
        end
        mode <= smp_pkg::MODE_I2C; // filter stays off
        for (i = 0; i < 7; i++) begin
            @(posedge clk);
            {ser_scl, ser_sda, stop_req} <= PIN_TAB[i][4:2];
            wr_reg(CA, PIN_TAB[i][12:5]);
            settle(5);
            chk(16'({scl_oe, sda_oe}), 16'(PIN_TAB[i][1:0]));
            chk(16'({scl_lvl, sda_lvl}), {14'h0000, ~PIN_TAB[i][1:0]});
        end
        @(posedge clk);
        {ser_scl, ser_sda, stop_req} <= 3'h0;
        wr_reg(CA, 8'h00);
        cond_run(8'h09, 1'h0, 1, 0);
        cond_run(8'h0A, 1'h0, 1, 0);
        cond_run(8'h0C, 1'h0, 0, 1);
        cond_run(8'h01, 1'h0, 0, 0);
        cond_run(8'h04, 1'h0, 0, 0);
        cond_run(8'h0D, 1'h1, 1, 0);
        chk(16'(busy_seen), 16'h0001);
        chk(16'({scl_out, sda_out}), 16'h0000);
        close_out();
    end
endmodule
